/* rtl/epw_pkg.sv */
// Package with shared constants and types for the page write host controller.
package epw_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned ADDR_W         = 11;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned PAGE_BYTES     = 32;
  localparam int unsigned COL_W          = 5;
  localparam int unsigned STROBE_LOW_NS  = 100;
  localparam int unsigned SETUP_NS       = 50;
  localparam int unsigned GAP_MIN_NS     = 200;
  localparam int unsigned WINDOW_MAX_NS  = 100000;
  localparam int unsigned RECOVERY_NS    = 50;
  localparam int unsigned READ_ACCESS_NS = 150;
  localparam int unsigned POWERUP_NS     = 2000000;
  localparam int unsigned BUSY_DELAY_NS  = 100;
  localparam int unsigned STROBE_LOW_CYC  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAP_MIN_CYC     = (GAP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WINDOW_EXP_CYC  = (WINDOW_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
  localparam int unsigned RECOVERY_CYC    = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READ_CYC        = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
  localparam int unsigned POWERUP_CYC     = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BUSY_DELAY_CYC  = (BUSY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
  localparam int unsigned CNT_W           = 17;
  localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  typedef enum logic [3:0] {
    EPW_IDLE    = 4'h0,
    EPW_SETUP   = 4'h1,
    EPW_STROBE  = 4'h2,
    EPW_HOLD    = 4'h3,
    EPW_GAP     = 4'h4,
    EPW_EXPIRE  = 4'h5,
    EPW_POLL    = 4'h6,
    EPW_RECOVER = 4'h7,
    EPW_READ    = 4'h8,
    EPW_RDONE   = 4'h9
  } epw_state_e;
endpackage : epw_pkg

/* rtl/epw_sync_if.sv */
// Interface carrying the synchronised pin levels between the synchroniser and the controller.
interface epw_sync_if;
  import epw_pkg::*;
  logic              ready_busy_n;
  logic [DATA_W-1:0] data;
  modport src (output ready_busy_n, output data);
  modport dst (input ready_busy_n, input data);
endinterface : epw_sync_if

/* rtl/epw_pin_sync.sv */
// Two-stage synchroniser for the device pins read by the controller.
module epw_pin_sync
  import epw_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_ready_busy_n,
  input  wire logic [DATA_W-1:0] i_data,
  epw_sync_if.src                sync
);
  logic [DATA_W:0] stage1;
  logic [DATA_W:0] stage2;
  logic [DATA_W:0] next_stage1;
  logic [DATA_W:0] next_stage2;

  always_comb begin
    next_stage1 = {i_ready_busy_n, i_data};
    next_stage2 = stage1;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      stage1 <= {1'b1, DATA_RST};
      stage2 <= {1'b1, DATA_RST};
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign sync.ready_busy_n = stage2[DATA_W];
  assign sync.data         = stage2[DATA_W-1:0];
endmodule : epw_pin_sync

/* rtl/epw_host_ctrl.sv */
// Host controller that drives the page write memory through its parallel pins.
module epw_host_ctrl
  import epw_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = POWERUP_CYC,
  parameter int unsigned WINDOW_CYCLES  = WINDOW_EXP_CYC
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_wr_valid,
  input  wire logic [ADDR_W-1:0] i_wr_addr,
  input  wire logic [DATA_W-1:0] i_wr_data,
  input  wire logic              i_wr_last,
  input  wire logic              i_rd_valid,
  input  wire logic [ADDR_W-1:0] i_rd_addr,
  input  wire logic              i_ready_busy_n,
  input  wire logic [DATA_W-1:0] i_data,
  output logic                   o_ready,
  output logic                   o_rd_done,
  output logic      [DATA_W-1:0] o_rd_data,
  output logic                   o_page_done,
  output logic      [ADDR_W-1:0] o_addr,
  output logic      [DATA_W-1:0] o_data,
  output logic                   o_data_oe,
  output logic                   o_chip_select_n,
  output logic                   o_output_enable_n,
  output logic                   o_write_strobe_n
);
  epw_sync_if sync ();

  epw_pin_sync u_sync (
    .i_sys_clk      (i_sys_clk),
    .i_rst_n        (i_rst_n),
    .i_ready_busy_n (i_ready_busy_n),
    .i_data         (i_data),
    .sync           (sync)
  );

  epw_state_e        state;
  epw_state_e        next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [CNT_W+4:0]  pwr_cnt;
  logic [CNT_W+4:0]  next_pwr_cnt;
  logic [COL_W:0]    loaded;
  logic [COL_W:0]    next_loaded;
  logic              last;
  logic              next_last;
  logic [DATA_W-1:0] last_byte;
  logic [DATA_W-1:0] next_last_byte;
  logic              ready;
  logic              next_ready;
  logic              rd_done;
  logic              next_rd_done;
  logic [DATA_W-1:0] rd_data;
  logic [DATA_W-1:0] next_rd_data;
  logic              page_done;
  logic              next_page_done;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic [DATA_W-1:0] data;
  logic [DATA_W-1:0] next_data;
  logic              data_oe;
  logic              next_data_oe;
  logic              cs_n;
  logic              next_cs_n;
  logic              oe_n;
  logic              next_oe_n;
  logic              we_n;
  logic              next_we_n;
  logic              powered;

  assign powered = (pwr_cnt >= (CNT_W+5)'(POWERUP_CYCLES));

  always_comb begin
    next_state     = state;
    next_cnt       = (cnt == '0) ? cnt : cnt - 1'b1;
    next_pwr_cnt   = powered ? pwr_cnt : pwr_cnt + 1'b1;
    next_loaded    = loaded;
    next_last      = last;
    next_last_byte = last_byte;
    next_ready     = 1'b0;
    next_rd_done   = 1'b0;
    next_rd_data   = rd_data;
    next_page_done = 1'b0;
    next_addr      = addr;
    next_data      = data;
    next_data_oe   = data_oe;
    next_cs_n      = cs_n;
    next_oe_n      = oe_n;
    next_we_n      = 1'b1;
    unique case (state)
      EPW_IDLE: begin
        if (i_rd_valid) begin
          next_addr  = i_rd_addr;
          next_cs_n  = 1'b0;
          next_oe_n  = 1'b0;
          next_cnt   = CNT_W'(READ_CYC);
          next_state = EPW_READ;
        end else if (i_wr_valid && powered) begin
          next_addr      = i_wr_addr;
          next_data      = i_wr_data;
          next_last      = i_wr_last;
          next_last_byte = i_wr_data;
          next_oe_n      = 1'b1;
          next_data_oe   = 1'b1;
          next_cs_n      = 1'b0;
          next_cnt       = CNT_W'(SETUP_CYC);
          next_state     = EPW_SETUP;
        end else begin
          next_ready = !ready;
        end
      end
      EPW_SETUP: begin
        if (cnt == '0) begin
          next_we_n  = 1'b0;
          next_cnt   = CNT_W'(STROBE_LOW_CYC - 1);
          next_state = EPW_STROBE;
        end
      end
      EPW_STROBE: begin
        next_we_n = (cnt == '0);
        if (cnt == '0) begin
          next_loaded = (loaded == (COL_W+1)'(PAGE_BYTES)) ? loaded : loaded + 1'b1;
          next_cnt    = CNT_W'(GAP_MIN_CYC);
          next_state  = EPW_HOLD;
        end
      end
      EPW_HOLD: begin
        if (cnt == '0) begin
          next_data_oe = 1'b0;
          if (last || loaded == (COL_W+1)'(PAGE_BYTES)) begin
            next_cs_n  = 1'b1;
            next_cnt   = CNT_W'(WINDOW_CYCLES);
            next_state = EPW_EXPIRE;
          end else begin
            next_cnt   = CNT_W'(WINDOW_CYCLES - GAP_MIN_CYC - 4);
            next_state = EPW_GAP;
            next_ready = 1'b1;
          end
        end
      end
      EPW_GAP: begin
        if (i_wr_valid && cnt != '0) begin
          next_addr      = i_wr_addr;
          next_data      = i_wr_data;
          next_last      = i_wr_last;
          next_last_byte = i_wr_data;
          next_data_oe   = 1'b1;
          next_cnt       = CNT_W'(SETUP_CYC);
          next_state     = EPW_SETUP;
        end else if (cnt == '0) begin
          next_cs_n  = 1'b1;
          next_cnt   = CNT_W'(WINDOW_CYCLES);
          next_state = EPW_EXPIRE;
        end else begin
          next_ready = !ready;
        end
      end
      EPW_EXPIRE: begin
        if (cnt == '0) begin
          next_cnt   = CNT_W'(BUSY_DELAY_CYC);
          next_cs_n  = 1'b0;
          next_oe_n  = 1'b0;
          next_state = EPW_POLL;
        end
      end
      EPW_POLL: begin
        if (cnt == '0 && sync.ready_busy_n &&
            sync.data[DATA_W-1] == last_byte[DATA_W-1]) begin
          next_cs_n   = 1'b1;
          next_oe_n   = 1'b1;
          next_cnt    = CNT_W'(RECOVERY_CYC + 2);
          next_state  = EPW_RECOVER;
        end
      end
      EPW_RECOVER: begin
        if (cnt == '0) begin
          next_loaded    = '0;
          next_page_done = 1'b1;
          next_state     = EPW_IDLE;
        end
      end
      EPW_READ: begin
        if (cnt == '0) begin
          next_rd_data = sync.data;
          next_cs_n    = 1'b1;
          next_oe_n    = 1'b1;
          next_state   = EPW_RDONE;
        end
      end
      EPW_RDONE: begin
        next_rd_done = 1'b1;
        next_state   = EPW_IDLE;
      end
      default: begin
        next_state = EPW_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state     <= EPW_IDLE;
      cnt       <= '0;
      pwr_cnt   <= '0;
      loaded    <= '0;
      last      <= 1'b0;
      last_byte <= DATA_RST;
      ready     <= 1'b0;
      rd_done   <= 1'b0;
      rd_data   <= DATA_RST;
      page_done <= 1'b0;
      addr      <= ADDR_RST;
      data      <= DATA_RST;
      data_oe   <= 1'b0;
      cs_n      <= 1'b1;
      oe_n      <= 1'b1;
      we_n      <= 1'b1;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      pwr_cnt   <= next_pwr_cnt;
      loaded    <= next_loaded;
      last      <= next_last;
      last_byte <= next_last_byte;
      ready     <= next_ready;
      rd_done   <= next_rd_done;
      rd_data   <= next_rd_data;
      page_done <= next_page_done;
      addr      <= next_addr;
      data      <= next_data;
      data_oe   <= next_data_oe;
      cs_n      <= next_cs_n;
      oe_n      <= next_oe_n;
      we_n      <= next_we_n;
    end
  end

  assign o_ready           = ready;
  assign o_rd_done         = rd_done;
  assign o_rd_data         = rd_data;
  assign o_page_done       = page_done;
  assign o_addr            = addr;
  assign o_data            = data;
  assign o_data_oe         = data_oe;
  assign o_chip_select_n   = cs_n;
  assign o_output_enable_n = oe_n;
  assign o_write_strobe_n  = we_n;
endmodule : epw_host_ctrl

/* dv/epw_host_assertions.sv */
// Checker of the pin protocol seen at the host controller ports.
module epw_host_assertions
  import epw_pkg::*;
(
  input wire logic              i_sys_clk,
  input wire logic              i_rst_n,
  input wire logic              i_ready_busy_n,
  input wire logic              o_page_done,
  input wire logic [ADDR_W-1:0] o_addr,
  input wire logic [DATA_W-1:0] o_data,
  input wire logic              o_data_oe,
  input wire logic              o_chip_select_n,
  input wire logic              o_output_enable_n,
  input wire logic              o_write_strobe_n
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  property p_rd; !o_output_enable_n |-> !o_chip_select_n && o_write_strobe_n && !o_data_oe; endproperty
  a_rd: assert property (p_rd) else $error("bad read pins");
  property p_we; !o_write_strobe_n |-> !o_chip_select_n && o_output_enable_n && o_data_oe && $stable(o_addr); endproperty
  a_we: assert property (p_we) else $error("bad load pins");
  property p_wid; $fell(o_write_strobe_n) |-> !o_write_strobe_n [*4] ##[1:3] o_write_strobe_n; endproperty
  a_wid: assert property (p_wid) else $error("bad strobe width");
  property p_hold; $rose(o_write_strobe_n) |-> o_data_oe && $stable(o_data) && $stable(o_addr); endproperty
  a_hold: assert property (p_hold) else $error("bad data hold");
  property p_gap; $rose(o_write_strobe_n) |-> o_write_strobe_n [*8]; endproperty
  a_gap: assert property (p_gap) else $error("strobe gap too short");
  property p_rec; $rose(i_ready_busy_n) |-> o_write_strobe_n [*4]; endproperty
  a_rec: assert property (p_rec) else $error("no recovery after busy");
  property p_bsy; !i_ready_busy_n |-> o_write_strobe_n; endproperty
  a_bsy: assert property (p_bsy) else $error("load while busy");
  property p_done; o_page_done |-> i_ready_busy_n && o_chip_select_n && o_output_enable_n; endproperty
  a_done: assert property (p_done) else $error("early page done");
endmodule : epw_host_assertions
bind epw_host_ctrl epw_host_assertions u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ready_busy_n(i_ready_busy_n), .o_page_done(o_page_done),
  .o_addr(o_addr), .o_data(o_data), .o_data_oe(o_data_oe), .o_chip_select_n(o_chip_select_n),
  .o_output_enable_n(o_output_enable_n), .o_write_strobe_n(o_write_strobe_n)
);

/* dv/epw_dev_model.sv */
// Behavioural model of the page write memory driven by the controller.
module epw_dev_model
  import epw_pkg::*;
#(
  parameter int WIN_NS  = 1000,
  parameter int BUSY_NS = 2000,
  parameter int LOCK_NS = 400
) (
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [DATA_W-1:0] i_data,
  input  wire logic              i_chip_select_n,
  input  wire logic              i_output_enable_n,
  input  wire logic              i_write_strobe_n,
  output logic      [DATA_W-1:0] o_data,
  output logic      [DATA_W-1:0] o_data_en,
  output logic                   o_busy_drive
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0]     mem [2**ADDR_W];
  logic [DATA_W-1:0]     pbuf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] loaded = '0;
  logic [ADDR_W-1:0]     la;
  logic [DATA_W-1:0]     last;
  logic                  busy = 1'b0;
  realtime               t_fall;
  realtime               t_rise;
  wire strobe_n = i_chip_select_n | i_write_strobe_n | ~i_output_enable_n;
  wire rd = ~i_chip_select_n & ~i_output_enable_n & i_write_strobe_n;
  initial for (int i = 0; i < 2**ADDR_W; i++) mem[i] = 8'(i) ^ 8'h5A;
  always @(negedge strobe_n) begin
    if (!busy && $realtime >= LOCK_NS) begin
      la = i_addr;
      t_fall = $realtime;
    end
  end
  always @(posedge strobe_n) begin
    if (!busy && $realtime >= LOCK_NS && $realtime - t_fall >= 20) begin
      pbuf[la[COL_W-1:0]] = i_data;
      loaded[la[COL_W-1:0]] = 1'b1;
      last = i_data;
      t_rise = $realtime;
    end
  end
  always #10 begin
    if (|loaded && strobe_n && !busy && $realtime - t_rise >= WIN_NS) begin
      busy = 1'b1;
      #BUSY_NS;
      for (int i = 0; i < PAGE_BYTES; i++) if (loaded[i]) mem[{la[ADDR_W-1:COL_W], 5'(i)}] = pbuf[i];
      loaded = '0;
      busy = 1'b0;
    end
  end
  assign o_busy_drive = busy;
  assign o_data_en = !rd ? 8'h00 : busy ? 8'h80 : 8'hFF;
  assign o_data = busy ? {~last[7], 7'h00} : mem[i_addr];
endmodule : epw_dev_model

/* dv/tb.sv */
// Self-checking testbench of the page write host controller.
module tb
  import epw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic              clk = 1'b0, rst_n = 1'b0, tog = 1'b0;
  logic              wr_valid = 1'b0, wr_last = 1'b0, rd_valid = 1'b0;
  logic [ADDR_W-1:0] wr_addr = '0, rd_addr = '0, addr;
  logic [DATA_W-1:0] wr_data = '0, rd_data, hd, dd, den, dq;
  logic              ready, rd_done, page_done, data_oe, cs_n, oe_n, we_n, rb_drv;
  int                mismatches = 0, comparisons = 0, cyc = 0;
  int                mdl [2**ADDR_W];
  int                pb [int];
  wire rb = ~rb_drv;
  assign dq = data_oe ? hd : (den & dd) | (~den & {DATA_W{tog}});
  always #12.5 clk = ~clk;
  epw_host_ctrl #(.POWERUP_CYCLES(20), .WINDOW_CYCLES(60)) uut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_wr_valid(wr_valid), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
    .i_wr_last(wr_last), .i_rd_valid(rd_valid), .i_rd_addr(rd_addr), .i_ready_busy_n(rb), .i_data(dq),
    .o_ready(ready), .o_rd_done(rd_done), .o_rd_data(rd_data), .o_page_done(page_done), .o_addr(addr),
    .o_data(hd), .o_data_oe(data_oe), .o_chip_select_n(cs_n), .o_output_enable_n(oe_n), .o_write_strobe_n(we_n)
  );
  epw_dev_model u_dev (
    .i_addr(addr), .i_data(dq), .i_chip_select_n(cs_n), .i_output_enable_n(oe_n), .i_write_strobe_n(we_n),
    .o_data(dd), .o_data_en(den), .o_busy_drive(rb_drv)
  );
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic req(input bit w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input bit l);
    int n;
    n = 0;
    @(negedge clk);
    while (ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    cmp({7'h00, ready}, 8'h01);
    {wr_addr, wr_data, wr_last, rd_addr} = {a, d, l, a};
    if (w) wr_valid = 1'b1;
    else rd_valid = 1'b1;
    @(negedge clk);
    wr_valid = 1'b0;
    rd_valid = 1'b0;
  endtask : req
  task automatic rd(input logic [ADDR_W-1:0] a);
    int n;
    n = 0;
    req(1'b0, a, 8'h00, 1'b0);
    while (rd_done !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    cmp({7'h00, rd_done}, 8'h01);
    cmp(rd_data, 8'(mdl[a]));
  endtask : rd
  always @(posedge clk) tog <= ~tog;
  always @(negedge clk) if (data_oe === 1'b1 && den !== 8'h00) cmp(den, 8'h00);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      $display("ERROR %0t timeout waiting for the run to finish", $time);
      test_done;
    end
  end
  initial begin
    int sz [4];
    int p, c, d, n;
    sz = '{1, 6, 32, 3};
    void'($urandom(15560));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    foreach (mdl[i]) mdl[i] = (i % 256) ^ 8'h5A;
    req(1'b1, 11'h2A5, 8'h3C, 1'b1);
    repeat (4) begin
      @(negedge clk);
      cmp({7'h00, cs_n}, 8'h01);
    end
    rd(11'h2A5);
    $display("lockout and read test done");
    repeat (30) @(negedge clk);
    foreach (sz[k]) begin
      p = $urandom_range(63);
      pb.delete();
      for (int i = 0; i < sz[k]; i++) begin
        c = (sz[k] == 32) ? i : $urandom_range(31);
        d = $urandom_range(255);
        pb[c] = d;
        req(1'b1, {6'(p), 5'(c)}, 8'(d), i == sz[k] - 1 && sz[k] < 6);
      end
      n = 0;
      while (page_done !== 1'b1 && n < 4000) begin
        @(negedge clk);
        n++;
      end
      cmp({7'h00, page_done}, 8'h01);
      foreach (pb[j]) mdl[{6'(p), 5'(j)}] = pb[j];
      for (int j = 0; j < 33; j++) rd({6'(p) + 6'(j / 32), 5'(j)});
      $display("case %0d done", k);
    end
    test_done;
  end
endmodule : tb
